// ===== logic/psl_pkg.sv
// Package of register map, field positions, reset values and timing counts for the sink block.
package psl_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_REG_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h23;
  localparam logic [7:0] ADDR_SEL_FIRST = 8'h24;
  localparam logic [7:0] ADDR_SEL_SECOND = 8'h25;
  localparam logic [7:0] ADDR_FLAGS_FIRST = 8'h2a;
  localparam logic [7:0] ADDR_FLAGS_SECOND = 8'h2b;
  localparam logic [7:0] ADDR_BOOST = 8'h30;
  localparam logic [7:0] ADDR_HW_CTRL = 8'h31;
  localparam logic [7:0] ADDR_AUDIO_MAP = 8'h32;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PUMP_ON_BIT = 2;
  localparam int MODE_LSB = 1;
  localparam int SWITCH_LSB = 3;
  localparam int LONG_DEB_BIT = 5;
  localparam int GP_C_MON_BIT = 4;
  localparam int HV_C_MON_BIT = 7;
  localparam int BOOST_BIT = 0;
  localparam int HW_STROBE_EN_BIT = 0;
  localparam int HW_STROBE_PAR_BIT = 1;
  localparam int HW_PREVIEW_EN_BIT = 2;
  localparam int HW_PWM_EN_BIT = 3;
  localparam int HW_PATTERN_EN_BIT = 4;
  localparam logic [7:0] SEL_FIRST_MASK = 8'h7f;
  localparam logic [7:0] SEL_SECOND_MASK = 8'h9f;
  localparam logic [7:0] HW_CTRL_MASK = 8'h1f;
  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_1X = 2'h0;
  localparam logic [1:0] MODE_1X5 = 2'h1;
  localparam logic [1:0] MODE_2X = 2'h2;
  localparam logic [1:0] SW_AUTO_ALL = 2'h0;
  localparam logic [1:0] SW_AUTO_LIMIT = 2'h1;
  localparam logic [1:0] AUDIO_NONE = 2'h3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AUDIO_MAP = 8'hff;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 25;
  localparam int DEB_SHORT_US = 240;
  localparam int DEB_LONG_US = 2000;
  localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ;
  localparam int DEB_LONG_CYC = DEB_LONG_US * CLK_MHZ;
  localparam int DEB_CNT_W = 16;
  typedef enum logic {DB_IDLE, DB_COUNT} psl_db_state_t;
endpackage

// ===== logic/psl_dbnc_if.sv
// Interface between the register logic and the mode-switch debounce timer.
`timescale 1ns/1ps
`default_nettype none
interface psl_dbnc_if;
  logic pump_on;
  logic enable;
  logic long_opt;
  logic low;
  logic step;
  modport ctl (output pump_on, output enable, output long_opt, output low, input step);
  modport tmr (input pump_on, input enable, input long_opt, input low, output step);
endinterface
`default_nettype wire

// ===== logic/psl_debounce.sv
// Debounce timer that asks for one pump up-step after a sustained low sink voltage.
`timescale 1ns/1ps
`default_nettype none
module psl_debounce #(
  parameter int SHORT_CYC = psl_pkg::DEB_SHORT_CYC,
  parameter int LONG_CYC = psl_pkg::DEB_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  psl_dbnc_if.tmr dbnc
);
  import psl_pkg::*;
  typedef struct packed {
    psl_db_state_t st;
    logic [DEB_CNT_W-1:0] cnt;
    logic first;
    logic step;
  } psl_db_t;
  psl_db_t q_ff;
  psl_db_t nxt_q;
  logic [DEB_CNT_W-1:0] limit;

  // ****************************************************************
  // Timer
  // ****************************************************************
  // The long start window only applies until the first up-step after pump start.
  assign limit = (q_ff.first && dbnc.long_opt) ? DEB_CNT_W'(LONG_CYC - 1) :
                 DEB_CNT_W'(SHORT_CYC - 1);
  always_comb begin
    nxt_q = q_ff;
    nxt_q.step = 1'b0;
    if (!dbnc.pump_on) begin
      nxt_q.first = 1'b1;
    end
    unique case (q_ff.st)
      DB_IDLE: begin
        nxt_q.cnt = '0;
        if (dbnc.enable && dbnc.low) begin
          nxt_q.st = DB_COUNT;
        end
      end
      DB_COUNT: begin
        if (!dbnc.enable || !dbnc.low) begin
          nxt_q.st = DB_IDLE;
          nxt_q.cnt = '0;
        end else if (q_ff.cnt >= limit) begin
          nxt_q.step = 1'b1;
          nxt_q.first = 1'b0;
          nxt_q.st = DB_IDLE;
          nxt_q.cnt = '0;
        end else begin
          nxt_q.cnt = q_ff.cnt + 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_ff <= '{st: DB_IDLE, cnt: '0, first: 1'b1, step: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign dbnc.step = q_ff.step;

  // ****************************************************************
  // Checks
  // ****************************************************************
  step_needs_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(q_ff.step) |-> $past(dbnc.low, 1) && $past(dbnc.low, 2) && $past(dbnc.enable, 1))
    else $error("Up-step without a sustained low sink.");
  short_window_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q_ff.step && !dbnc.long_opt) |-> $past(q_ff.cnt) == DEB_CNT_W'(SHORT_CYC - 1))
    else $error("Short debounce window has the wrong length.");
  step_cover_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) q_ff.step);
endmodule
`default_nettype wire

// ===== logic/psl_top.sv
// Sink selection, low-voltage status and pump auto-mode register block.
// ****************************************************************
// Function
// - Second select bit 4 monitors general sink c for pump mode; resets 0.
// - Second select bit 7 monitors high-voltage sink c; resets 0.
// - Each status bit reads 1 while its sink voltage is too low.
// - First status: parallel a-d, colour a-c, high-voltage c, low-class threshold.
// - Second status bits 0,1: high-voltage a,b against high-class threshold.
// - Second status bits 2-4: general sinks a-c against low-class threshold.
// - Status registers are read-only live values; writes do nothing.
// - Parallel sinks get the extended strobe range only when boost is set.
// - Strobe drives high-voltage a or parallel a; preview drives high-voltage b.
// - Parallel sinks map freely to audio channels; others fixed in order.
// - Auto mode steps pump up after debounce while a monitored sink is low.
// - Unselected sinks never cause a pump up-step.
// - Without the long start option the debounce is always 240 us.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module psl_top #(
  parameter int DEB_SHORT_CYC_P = psl_pkg::DEB_SHORT_CYC,
  parameter int DEB_LONG_CYC_P = psl_pkg::DEB_LONG_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [10:0] CMP_LV_IN,
  input wire logic [1:0] CMP_HV_IN,
  input wire logic STROBE_IN,
  input wire logic PREVIEW_IN,
  input wire logic PWM_IN,
  input wire logic PATTERN_IN,
  input wire logic [2:0] AUDIO_CH_IN,
  output logic [7:0] RDATA_OUT,
  output logic [1:0] PUMP_MODE_OUT,
  output logic PAR_RANGE_EXT_OUT,
  output logic HV_A_HW_ON_OUT,
  output logic PAR_A_HW_ON_OUT,
  output logic HV_B_HW_ON_OUT,
  output logic [3:0] PAR_AUDIO_OUT,
  output logic [2:0] HV_AUDIO_OUT,
  output logic [2:0] COL_AUDIO_OUT,
  output logic [2:0] GP_AUDIO_OUT
);
  import psl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic pump_on;
    logic [1:0] mode;
    logic [1:0] sw;
    logic long_opt;
    logic [6:0] sel1;
    logic [7:0] sel2;
    logic boost;
    logic [4:0] hwctl;
    logic [7:0] audio;
    logic [10:0] s1_lv;
    logic [10:0] s2_lv;
    logic [1:0] s1_hv;
    logic [1:0] s2_hv;
    logic any_low;
    logic [7:0] rdata;
    logic hv_a_hw;
    logic par_a_hw;
    logic hv_b_hw;
    logic [3:0] par_aud;
    logic [2:0] fix_aud;
  } psl_top_state_t;
  psl_top_state_t q_ff;
  psl_top_state_t nxt_q;
  psl_dbnc_if dbnc ();
  logic auto_sw;
  logic [1:0] mode_limit;
  logic [3:0] par_aud_sel;
  logic [10:0] lv_mon;
  logic [1:0] hv_mon;
  logic hw_src;

  // ****************************************************************
  // Monitor selection and auto mode
  // ****************************************************************
  // Sink order of the low-class comparators: parallel a-d, colour a-c,
  // high-voltage c, general a-c. Only synchronised copies are looked at.
  assign lv_mon = {q_ff.sel2[GP_C_MON_BIT:2], q_ff.sel2[HV_C_MON_BIT], q_ff.sel1};
  assign hv_mon = q_ff.sel2[1:0];
  assign auto_sw = q_ff.sw == SW_AUTO_ALL || q_ff.sw == SW_AUTO_LIMIT;
  assign mode_limit = (q_ff.sw == SW_AUTO_ALL) ? MODE_2X : MODE_1X5;
  assign dbnc.pump_on = q_ff.pump_on;
  assign dbnc.enable = q_ff.pump_on && auto_sw && q_ff.mode != mode_limit;
  assign dbnc.long_opt = q_ff.long_opt;
  assign dbnc.low = q_ff.any_low;

  psl_debounce #(
    .SHORT_CYC(DEB_SHORT_CYC_P),
    .LONG_CYC(DEB_LONG_CYC_P)
  ) u_debounce (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESETN_IN),
    .dbnc(dbnc.tmr)
  );

  // ****************************************************************
  // Audio channel routing
  // ****************************************************************
  generate
    for (genvar i = 0; i < 4; i++) begin : g_par_aud
      assign par_aud_sel[i] = (q_ff.audio[2*i+1:2*i] == AUDIO_NONE) ? 1'b0 :
                              AUDIO_CH_IN[q_ff.audio[2*i+1:2*i]];
    end
  endgenerate
  assign hw_src = (q_ff.hwctl[HW_PWM_EN_BIT] && PWM_IN) ||
                  (q_ff.hwctl[HW_PATTERN_EN_BIT] && PATTERN_IN);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_q = q_ff;
    // Two flops per comparator; only the second rank feeds status and debounce.
    nxt_q.s1_lv = CMP_LV_IN;
    nxt_q.s2_lv = q_ff.s1_lv;
    nxt_q.s1_hv = CMP_HV_IN;
    nxt_q.s2_hv = q_ff.s1_hv;
    nxt_q.any_low = |(q_ff.s2_lv & lv_mon) || |(q_ff.s2_hv & hv_mon);
    nxt_q.hv_a_hw = hw_src || (q_ff.hwctl[HW_STROBE_EN_BIT] &&
                    !q_ff.hwctl[HW_STROBE_PAR_BIT] && STROBE_IN);
    nxt_q.par_a_hw = hw_src || (q_ff.hwctl[HW_STROBE_EN_BIT] &&
                     q_ff.hwctl[HW_STROBE_PAR_BIT] && STROBE_IN);
    nxt_q.hv_b_hw = hw_src || (q_ff.hwctl[HW_PREVIEW_EN_BIT] && PREVIEW_IN);
    nxt_q.par_aud = par_aud_sel;
    nxt_q.fix_aud = AUDIO_CH_IN;
    // Up-step from the debounce timer; capped at the limit of the chosen algorithm.
    if (dbnc.step && auto_sw && q_ff.pump_on && q_ff.mode != mode_limit) begin
      nxt_q.mode = q_ff.mode + 2'h1;
    end
    if (WR_IN) begin
      unique case (ADDR_IN)
        ADDR_REG_CTRL: nxt_q.pump_on = WDATA_IN[PUMP_ON_BIT];
        ADDR_PUMP_CTRL: begin
          nxt_q.sw = WDATA_IN[SWITCH_LSB+:2];
          nxt_q.long_opt = WDATA_IN[LONG_DEB_BIT];
          // In auto modes the mode field reports, so a write to it is dropped.
          if (!auto_sw && WDATA_IN[MODE_LSB+:2] != 2'h3) begin
            nxt_q.mode = WDATA_IN[MODE_LSB+:2];
          end
        end
        ADDR_SEL_FIRST: nxt_q.sel1 = WDATA_IN[6:0] & SEL_FIRST_MASK[6:0];
        ADDR_SEL_SECOND: nxt_q.sel2 = WDATA_IN & SEL_SECOND_MASK;
        ADDR_BOOST: nxt_q.boost = WDATA_IN[BOOST_BIT];
        ADDR_HW_CTRL: nxt_q.hwctl = WDATA_IN[4:0] & HW_CTRL_MASK[4:0];
        ADDR_AUDIO_MAP: nxt_q.audio = WDATA_IN;
        default: nxt_q.rdata = q_ff.rdata; // Status and unmapped: ignored.
      endcase
    end
    // A pump switched off falls back to the 1:1 mode.
    if (!q_ff.pump_on) begin
      nxt_q.mode = MODE_1X;
    end
    nxt_q.rdata = RST_ZERO;
    if (RD_IN) begin
      unique case (ADDR_IN)
        ADDR_REG_CTRL: nxt_q.rdata[PUMP_ON_BIT] = q_ff.pump_on;
        ADDR_PUMP_CTRL: nxt_q.rdata = {2'h0, q_ff.long_opt, q_ff.sw, q_ff.mode, 1'b0};
        ADDR_SEL_FIRST: nxt_q.rdata = {1'b0, q_ff.sel1};
        ADDR_SEL_SECOND: nxt_q.rdata = q_ff.sel2;
        ADDR_FLAGS_FIRST: nxt_q.rdata = q_ff.s2_lv[7:0];
        ADDR_FLAGS_SECOND: nxt_q.rdata = {3'h0, q_ff.s2_lv[10:8], q_ff.s2_hv};
        ADDR_BOOST: nxt_q.rdata[BOOST_BIT] = q_ff.boost;
        ADDR_HW_CTRL: nxt_q.rdata = {3'h0, q_ff.hwctl};
        ADDR_AUDIO_MAP: nxt_q.rdata = q_ff.audio;
        default: nxt_q.rdata = RST_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      q_ff <= '0;
      q_ff.audio <= RST_AUDIO_MAP;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign RDATA_OUT = q_ff.rdata;
  assign PUMP_MODE_OUT = q_ff.mode;
  assign PAR_RANGE_EXT_OUT = q_ff.boost;
  assign HV_A_HW_ON_OUT = q_ff.hv_a_hw;
  assign PAR_A_HW_ON_OUT = q_ff.par_a_hw;
  assign HV_B_HW_ON_OUT = q_ff.hv_b_hw;
  assign PAR_AUDIO_OUT = q_ff.par_aud;
  assign HV_AUDIO_OUT = q_ff.fix_aud;
  assign COL_AUDIO_OUT = q_ff.fix_aud;
  assign GP_AUDIO_OUT = q_ff.fix_aud;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sel_reset_a: assert property (@(posedge CLK_SYS_IN)
    $rose(RESETN_IN) |-> q_ff.sel2[GP_C_MON_BIT] == 1'b0 && q_ff.sel2[HV_C_MON_BIT] == 1'b0)
    else $error("Second select register not cleared by reset.");
  sel_readback_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (WR_IN && ADDR_IN == ADDR_SEL_SECOND) ##1 (RD_IN && ADDR_IN == ADDR_SEL_SECOND)
    |=> RDATA_OUT == ($past(WDATA_IN, 2) & SEL_SECOND_MASK))
    else $error("Second select register read back wrong.");
  flags_first_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (RD_IN && ADDR_IN == ADDR_FLAGS_FIRST && $past(RESETN_IN, 1) && $past(RESETN_IN, 2))
    |=> RDATA_OUT == $past(CMP_LV_IN[7:0], 3))
    else $error("First status register does not show the live comparators.");
  flags_second_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (RD_IN && ADDR_IN == ADDR_FLAGS_SECOND && $past(RESETN_IN, 1) && $past(RESETN_IN, 2))
    |=> RDATA_OUT == {3'h0, $past(CMP_LV_IN[10:8], 3), $past(CMP_HV_IN, 3)})
    else $error("Second status register does not show the live comparators.");
  status_ro_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (WR_IN && (ADDR_IN == ADDR_FLAGS_FIRST || ADDR_IN == ADDR_FLAGS_SECOND))
    |=> q_ff.s2_lv == $past(q_ff.s1_lv) && q_ff.s2_hv == $past(q_ff.s1_hv))
    else $error("A write disturbed the status registers.");
  sync_depth_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    $past(RESETN_IN, 2) |-> q_ff.s2_lv == $past(CMP_LV_IN, 2))
    else $error("Comparator synchroniser is not two flops deep.");
  no_select_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (q_ff.sel1 == 7'h00 && q_ff.sel2 == RST_ZERO) |=> !q_ff.any_low)
    else $error("Unselected sink raised the low indication.");
  boost_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (WR_IN && ADDR_IN == ADDR_BOOST) |=> PAR_RANGE_EXT_OUT == $past(WDATA_IN[BOOST_BIT]))
    else $error("Extended range output does not follow the boost bit.");
  strobe_route_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (STROBE_IN && q_ff.hwctl == 5'h01) |=> HV_A_HW_ON_OUT && !PAR_A_HW_ON_OUT)
    else $error("Strobe not routed to high-voltage sink a.");
  audio_map_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (q_ff.audio[1:0] == 2'h1) |=> PAR_AUDIO_OUT[0] == $past(AUDIO_CH_IN[1]))
    else $error("Parallel sink a not following its audio channel.");
  mode_step_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (dbnc.step && q_ff.pump_on && q_ff.sw == SW_AUTO_ALL && q_ff.mode == MODE_1X && !WR_IN)
    |=> q_ff.mode == MODE_1X5)
    else $error("Pump did not step up after debounce.");
  mode_2x_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) q_ff.mode == MODE_2X);
  flag_read_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (RD_IN && ADDR_IN == ADDR_FLAGS_SECOND) ##1 RDATA_OUT != RST_ZERO);
  strobe_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) PAR_A_HW_ON_OUT);
endmodule
`default_nettype wire

// ===== tb/tb_pump_sink_lowvolt_status.sv
// Self-checking testbench for the sink selection, low-voltage status and pump auto-mode block.
`timescale 1ns/1ps
`default_nettype none
module tb_pump_sink_lowvolt_status;
  import psl_pkg::*;
  // Short debounce counts keep the pump stepping scenarios brief.
  localparam int SHORT = 8;
  localparam int LONG = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [10:0] cmp_lv = 11'h000;
  logic [1:0] cmp_hv = 2'h0;
  logic strobe = 1'b0;
  logic preview = 1'b0;
  logic pwm = 1'b0;
  logic pattern = 1'b0;
  logic [2:0] audio = 3'h0;
  logic [7:0] rdata;
  logic [1:0] mode;
  logic range_ext;
  logic hv_a_on;
  logic par_a_on;
  logic hv_b_on;
  logic [3:0] par_audio;
  logic [2:0] hv_audio;
  logic [2:0] col_audio;
  logic [2:0] gp_audio;
  int fails = 0;
  int checks = 0;
  int seed = 32'h6fbd19dc;
  logic [7:0] v;
  logic [7:0] map;
  logic [2:0] hw_exp;

  always #20 clk = ~clk;

  psl_top #(.DEB_SHORT_CYC_P(SHORT), .DEB_LONG_CYC_P(LONG)) psl_top_i (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .CMP_LV_IN(cmp_lv), .CMP_HV_IN(cmp_hv), .STROBE_IN(strobe),
    .PREVIEW_IN(preview), .PWM_IN(pwm), .PATTERN_IN(pattern), .AUDIO_CH_IN(audio),
    .RDATA_OUT(rdata), .PUMP_MODE_OUT(mode), .PAR_RANGE_EXT_OUT(range_ext),
    .HV_A_HW_ON_OUT(hv_a_on), .PAR_A_HW_ON_OUT(par_a_on), .HV_B_HW_ON_OUT(hv_b_on),
    .PAR_AUDIO_OUT(par_audio), .HV_AUDIO_OUT(hv_audio), .COL_AUDIO_OUT(col_audio),
    .GP_AUDIO_OUT(gp_audio));

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  function automatic logic [7:0] exp_flags2(input logic [10:0] lv, input logic [1:0] hv);
    return {3'h0, lv[10:8], hv};
  endfunction

  // PWM and pattern sources switch all three hardware-controlled sinks together.
  function automatic logic [2:0] exp_hw(input logic [7:0] c, input logic s, input logic p,
    input logic w, input logic t);
    logic h;
    h = (w & c[3]) | (t & c[4]);
    return {(s & c[0] & ~c[1]) | h, (s & c[0] & c[1]) | h, (p & c[2]) | h};
  endfunction

  function automatic logic [3:0] exp_par_audio(input logic [7:0] m, input logic [2:0] au);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i] = (m[2*i+:2] == 2'h3) ? 1'b0 : au[m[2*i+:2]];
    end
    return r;
  endfunction

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // A write followed by a read of the same register with no gap between the strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
    input string what);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(what, exp, rdata);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(what, exp, rdata);
  endtask

  task automatic mode_wait(input logic [1:0] exp, input int lo, input int hi, input string what);
    int n;
    n = 0;
    while (mode !== exp && n <= hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    check8(what, 8'h01, {7'h00, (n >= lo && n <= hi)});
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    #(40 * 20000);
    fails++;
    results();
  end

  initial begin
    do_reset();
    check_rd(ADDR_SEL_SECOND, RST_ZERO, "select second reset");
    check_rd(ADDR_BOOST, RST_ZERO, "boost reset");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h90 : (i == 1) ? 8'h6f : 8'($random(seed));
      wr_rd(ADDR_SEL_SECOND, v, v & SEL_SECOND_MASK, "select second");
    end
    // Status bits follow the live comparators; software writes must not stick.
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      cmp_lv <= (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($random(seed));
      cmp_hv <= (i == 0) ? 2'h3 : 2'($random(seed));
      repeat (3) @(posedge clk);
      wr_reg(ADDR_FLAGS_FIRST, ~cmp_lv[7:0]);
      wr_reg(ADDR_FLAGS_SECOND, 8'hff);
      check_rd(ADDR_FLAGS_FIRST, cmp_lv[7:0], "flags first");
      v = exp_flags2(cmp_lv, cmp_hv);
      check_rd(ADDR_FLAGS_SECOND, v, "flags second");
    end
    wr_reg(8'h7e, 8'h5a);
    check_rd(8'h7e, 8'h00, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_BOOST, {7'h00, ~i[0]});
      repeat (2) @(posedge clk);
      #1;
      check8("range extension", {7'h00, ~i[0]}, {7'h00, range_ext});
    end
    // Hardware sources and audio channels; strobe and preview first, then every source at random.
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? {5'h00, i[1], i[0], 1'b1} : (8'($random(seed)) & 8'h1f);
      map = (i == 0) ? RST_AUDIO_MAP : (i == 1) ? 8'he4 : 8'($random(seed));
      wr_reg(ADDR_HW_CTRL, v);
      wr_reg(ADDR_AUDIO_MAP, map);
      @(posedge clk);
      strobe <= (i < 4) ? 1'b1 : 1'($random(seed));
      preview <= (i < 4) ? 1'b1 : 1'($random(seed));
      pwm <= 1'($random(seed));
      pattern <= 1'($random(seed));
      audio <= 3'($random(seed));
      @(posedge clk);
      #1;
      hw_exp = exp_hw(v, strobe, preview, pwm, pattern);
      check8("hw on", {5'h00, hw_exp}, {5'h00, hv_a_on, par_a_on, hv_b_on});
      check8("par audio", {4'h0, exp_par_audio(map, audio)}, {4'h0, par_audio});
      check8("fixed audio", {2'h0, audio, audio}, {2'h0, hv_audio, col_audio});
      check8("gp audio", {5'h00, audio}, {5'h00, gp_audio});
    end
    // Auto mode: unselected low sinks never step the pump.
    wr_reg(ADDR_PUMP_CTRL, 8'h00);
    wr_reg(ADDR_SEL_FIRST, 8'h00);
    wr_reg(ADDR_SEL_SECOND, 8'h0f);
    @(posedge clk);
    cmp_lv <= 11'h4ff;
    cmp_hv <= 2'h0;
    wr_reg(ADDR_REG_CTRL, 8'h04);
    repeat (40) @(posedge clk);
    #1;
    check8("mode unselected", 8'h00, {6'h00, mode});
    wr_reg(ADDR_SEL_SECOND, 8'h1f);
    mode_wait(MODE_1X5, SHORT - 2, SHORT + 8, "first step time");
    mode_wait(MODE_2X, SHORT - 2, SHORT + 8, "second step time");
    repeat (30) @(posedge clk);
    #1;
    check8("mode at limit", {6'h00, MODE_2X}, {6'h00, mode});
    wr_reg(ADDR_REG_CTRL, 8'h00);
    mode_wait(MODE_1X, 0, 3, "pump off");
    // Limited algorithm with the long start window on high-voltage sink c.
    wr_reg(ADDR_PUMP_CTRL, 8'h28);
    wr_reg(ADDR_SEL_SECOND, 8'h80);
    @(posedge clk);
    cmp_lv <= 11'h080;
    wr_reg(ADDR_REG_CTRL, 8'h04);
    mode_wait(MODE_1X5, LONG - 2, LONG + 8, "long start step");
    repeat (30) @(posedge clk);
    #1;
    check8("mode limited", {6'h00, MODE_1X5}, {6'h00, mode});
    // Manual switching goes through 1:1 before 1:2; the code 3 is refused.
    wr_reg(ADDR_PUMP_CTRL, 8'h10);
    wr_reg(ADDR_PUMP_CTRL, 8'h10);
    wr_reg(ADDR_PUMP_CTRL, 8'h14);
    check_rd(ADDR_PUMP_CTRL, 8'h14, "manual mode set");
    wr_reg(ADDR_PUMP_CTRL, 8'h16);
    check_rd(ADDR_PUMP_CTRL, 8'h14, "manual mode 3 dropped");
    check8("manual mode pin", {6'h00, MODE_2X}, {6'h00, mode});
    do_reset();
    check_rd(ADDR_SEL_SECOND, RST_ZERO, "select after reset");
    check8("mode after reset", 8'h00, {6'h00, mode});
    results();
  end
endmodule
`default_nettype wire
